// *** hw/fsao_top.v ***
`timescale 1ns/1ps
`include "fsao_defs.vh"

module fsao_top #(
  parameter NSIG = 8,
  parameter NTOG = 4,
  parameter CW   = 13
) (
  // Clock and reset
  input  wire            clk_i,
  input  wire            rst_i,
  // Register port
  input  wire [9:0]      reg_addr_i,
  input  wire [31:0]     reg_wdata_i,
  input  wire            reg_wr_i,
  input  wire            reg_rd_i,
  output reg  [31:0]     reg_rdata_o,
  // Field and position timing
  input  wire            field_sync_i,
  input  wire            pixel_tick_i,
  input  wire [CW-1:0]   line_i,
  input  wire [CW-1:0]   pixel_i,
  // Field counters
  input  wire [CW-1:0]   mode_field_i,
  input  wire [CW-1:0]   prim_field_i,
  input  wire            prim_active_i,
  input  wire [CW-1:0]   sec_field_i,
  input  wire            sec_active_i,
  // Alternate pin sources
  input  wire            raw_substrate_clock_i,
  input  wire            vert_clock_21_i,
  input  wire            vert_clock_22_i,
  input  wire            vert_clock_23_i,
  input  wire            vert_clock_24_i,
  input  wire            internal_clock_i,
  input  wire            optical_black_clamp_i,
  input  wire            delayed_sample_clock_i,
  // Aux pins
  input  wire [7:0]      aux_output_pin_i,
  output reg  [7:0]      aux_output_pin_o,
  output reg  [7:0]      aux_output_pin_oe_o
);

  localparam NT = NSIG * NTOG;

  // Configuration
  reg  [3*NSIG-1:0] link_q;
  reg  [NSIG-1:0]   fire_q;
  reg  [NSIG-1:0]   start_q;
  reg  [7:0]        src_q;
  reg  [7:0]        oe_q;
  reg  [7:0]        route_q;
  reg  [15:0]       table_q;
  reg               probe_q;
  reg  [CW-1:0]     tog_fd_q [0:NT-1];
  reg  [CW-1:0]     tog_ln_q [0:NT-1];
  reg  [CW-1:0]     tog_px_q [0:NT-1];
  reg               tog_en_q [0:NT-1];

  // Signal state
  reg  [NSIG-1:0]   level_q;
  reg  [NSIG-1:0]   level_d;
  reg  [NSIG-1:0]   armed_q;
  reg  [NSIG-1:0]   armed_d;
  reg  [NSIG-1:0]   man_act_q;
  reg  [NSIG-1:0]   man_act_d;
  reg  [7:0]        pin_in_q;
  reg  [7:0]        pin_d;

  reg  [CW-1:0]     cur_field;
  reg               run;
  reg               hit;
  reg               has_f1;
  reg  [2:0]        lnk;
  reg               lut_out;
  reg               sig_val;
  reg  [31:0]       rdata_d;
  integer           i;
  integer           t;
  integer           k;
  // Loop indices kept apart so each variable has one driving process
  integer           r;
  integer           j;

  wire              tog_sel = (reg_addr_i[9:8] == 2'b01);
  wire [4:0]        tog_idx = reg_addr_i[7:3];

  // Truth table bit picked by the upper and lower signal of a pair
  function lut_pick;
    input [3:0] tbl;
    input       hi;
    input       lo;
    begin
      lut_pick = tbl[{hi, lo}];
    end
  endfunction

  function [2:0] link_of;
    input [3*NSIG-1:0] l;
    input integer      n;
    begin
      link_of = l[3*n +: 3];
    end
  endfunction

  // Register writes
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_q  <= {3*NSIG{1'b0}};
      fire_q  <= {NSIG{1'b0}};
      start_q <= {NSIG{1'b0}};
      src_q   <= `FSAO_SRC_RESET;
      oe_q    <= `FSAO_OE_RESET;
      route_q <= 8'h00;
      table_q <= 16'h0000;
      probe_q <= 1'b0;
      for (r = 0; r < NT; r = r + 1) begin
        tog_fd_q[r] <= {CW{1'b0}};
        tog_ln_q[r] <= {CW{1'b0}};
        tog_px_q[r] <= {CW{1'b0}};
        tog_en_q[r] <= 1'b0;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `FSAO_ADDR_LINK)
        link_q <= reg_wdata_i[3*NSIG-1:0];
      if (reg_addr_i == `FSAO_ADDR_CTRL) begin
        fire_q  <= reg_wdata_i[7:0];
        start_q <= reg_wdata_i[15:8];
        src_q   <= reg_wdata_i[23:16];
        oe_q    <= reg_wdata_i[31:24];
      end
      if (reg_addr_i == `FSAO_ADDR_LUT) begin
        route_q <= reg_wdata_i[7:0];
        table_q <= reg_wdata_i[23:8];
        probe_q <= reg_wdata_i[24];
      end
      if (tog_sel && !reg_addr_i[2]) begin
        tog_ln_q[tog_idx] <= reg_wdata_i[CW-1:0];
        tog_px_q[tog_idx] <= reg_wdata_i[`FSAO_PX_LSB +: CW];
      end
      if (tog_sel && reg_addr_i[2]) begin
        tog_fd_q[tog_idx] <= reg_wdata_i[CW-1:0];
        tog_en_q[tog_idx] <= reg_wdata_i[`FSAO_TOG_EN_BIT];
      end
    end
  end

  // Per-signal next state
  always @* begin
    level_d   = level_q;
    armed_d   = armed_q;
    man_act_d = man_act_q;
    cur_field = {CW{1'b0}};
    run       = 1'b0;
    hit       = 1'b0;
    has_f1    = 1'b0;
    lnk       = 3'h0;
    for (i = 0; i < NSIG; i = i + 1) begin
      lnk    = link_of(link_q, i);
      hit    = 1'b0;
      has_f1 = 1'b0;
      for (t = 0; t < NTOG; t = t + 1) begin
        k = i * NTOG + t;
        if (tog_en_q[k] && tog_fd_q[k] == `FSAO_MANUAL_FIELD)
          has_f1 = 1'b1;
      end
      // Manual arm: a fire write while the next field starts still arms
      if (field_sync_i) begin
        man_act_d[i] = armed_q[i];
        armed_d[i]   = 1'b0;
      end
      if (lnk != `FSAO_LINK_MANUAL) begin
        armed_d[i]   = 1'b0;
        man_act_d[i] = 1'b0;
      end else if (reg_wr_i && reg_addr_i == `FSAO_ADDR_CTRL &&
                   reg_wdata_i[i]) begin
        armed_d[i] = 1'b1;
      end
      case (lnk)
        `FSAO_LINK_MANUAL: begin
          run       = man_act_q[i];
          cur_field = `FSAO_MANUAL_FIELD;
        end
        `FSAO_LINK_MODE: begin
          run       = 1'b1;
          cur_field = mode_field_i;
        end
        `FSAO_LINK_PRIM: begin
          run       = prim_active_i && has_f1;
          cur_field = prim_field_i;
        end
        `FSAO_LINK_SEC: begin
          run       = sec_active_i && has_f1;
          cur_field = sec_field_i;
        end
        default: begin
          run       = 1'b0;
          cur_field = {CW{1'b0}};
        end
      endcase
      for (t = 0; t < NTOG; t = t + 1) begin
        k = i * NTOG + t;
        if (tog_en_q[k] && tog_fd_q[k] == cur_field &&
            tog_ln_q[k] == line_i && tog_px_q[k] == pixel_i)
          hit = ~hit;
      end
      case (lnk)
        `FSAO_LINK_IDLE: level_d[i] = start_q[i];
        `FSAO_LINK_ON:   level_d[i] = 1'b1;
        default: begin
          if (run && pixel_tick_i && hit)
            level_d[i] = ~level_q[i];
        end
      endcase
    end
  end

  // Pin value composition
  always @* begin
    pin_d   = 8'h00;
    lut_out = 1'b0;
    sig_val = 1'b0;
    for (j = 0; j < 8; j = j + 1) begin
      // Pairs are fixed, the upper member is the high index bit
      lut_out = lut_pick(table_q[4*(j/2) +: 4],
                         level_q[2*(j/2)+1], level_q[2*(j/2)]);
      sig_val = route_q[j] ? lut_out : level_q[j];
      pin_d[j] = sig_val;
      if (!src_q[j]) begin
        case (j)
          0: pin_d[j] = probe_q ? internal_clock_i : sig_val;
          1: pin_d[j] = probe_q ? optical_black_clamp_i : sig_val;
          2: pin_d[j] = probe_q ? delayed_sample_clock_i : sig_val;
          3: pin_d[j] = raw_substrate_clock_i;
          4: pin_d[j] = vert_clock_21_i;
          5: pin_d[j] = vert_clock_22_i;
          6: pin_d[j] = vert_clock_23_i;
          7: pin_d[j] = vert_clock_24_i;
          default: pin_d[j] = sig_val;
        endcase
      end
    end
  end

  // Read mux
  always @* begin
    rdata_d = 32'h0000_0000;
    case (reg_addr_i)
      `FSAO_ADDR_LINK:   rdata_d[3*NSIG-1:0] = link_q;
      `FSAO_ADDR_CTRL:   rdata_d = {oe_q, src_q, start_q, fire_q};
      `FSAO_ADDR_LUT:    rdata_d[24:0] = {probe_q, table_q, route_q};
      `FSAO_ADDR_STATUS: rdata_d[15:0] = {pin_in_q, level_q};
      default: begin
        if (tog_sel && !reg_addr_i[2])
          rdata_d[`FSAO_PX_LSB+CW-1:0] = {tog_px_q[tog_idx],
                                          tog_ln_q[tog_idx]};
        else if (tog_sel)
          rdata_d = {tog_en_q[tog_idx], {(32-CW-1){1'b0}},
                     tog_fd_q[tog_idx]};
      end
    endcase
  end

  // State and output flops
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_q             <= {NSIG{1'b0}};
      armed_q             <= {NSIG{1'b0}};
      man_act_q           <= {NSIG{1'b0}};
      pin_in_q            <= 8'h00;
      reg_rdata_o         <= 32'h0000_0000;
      aux_output_pin_o    <= 8'h00;
      aux_output_pin_oe_o <= 8'h00;
    end else begin
      level_q             <= level_d;
      armed_q             <= armed_d;
      man_act_q           <= man_act_d;
      pin_in_q            <= aux_output_pin_i;
      reg_rdata_o         <= reg_rd_i ? rdata_d : 32'h0000_0000;
      aux_output_pin_o    <= pin_d;
      aux_output_pin_oe_o <= oe_q;
    end
  end

endmodule

// *** hw/fsao_defs.vh ***
`ifndef FSAO_DEFS_VH
`define FSAO_DEFS_VH

`define FSAO_ADDR_LINK    10'h000
`define FSAO_ADDR_CTRL    10'h004
`define FSAO_ADDR_LUT     10'h008
`define FSAO_ADDR_STATUS  10'h00c
`define FSAO_ADDR_TOG     10'h100

`define FSAO_LINK_IDLE    3'h0
`define FSAO_LINK_MANUAL  3'h1
`define FSAO_LINK_MODE    3'h4
`define FSAO_LINK_PRIM    3'h5
`define FSAO_LINK_SEC     3'h6
`define FSAO_LINK_ON      3'h7

`define FSAO_SRC_RESET    8'hff
`define FSAO_OE_RESET     8'h00
`define FSAO_TOG_EN_BIT   31
`define FSAO_PX_LSB       13
`define FSAO_MANUAL_FIELD 13'h0001

`endif

// *** dv/fsao_asserts.sv ***
`timescale 1ns/1ps
module fsao_asserts (
  input wire        clk_i,
  input wire        rst_i,
  input wire [9:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        raw_substrate_clock_i,
  input wire        internal_clock_i,
  input wire [7:0]  aux_output_pin_i,
  input wire [7:0]  aux_output_pin_o,
  input wire [7:0]  aux_output_pin_oe_o
);
  // Shadows of the config words; pin level checks wait for a quiet bus
  reg [23:0] lk_q;
  reg [31:0] ct_q;
  reg [24:0] lt_q;
  reg [1:0]  qt_q;
  reg        ok_q;
  wire       st = ok_q && qt_q == 2'h3;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lk_q <= 24'h0;
      ct_q <= 32'h00ff0000;
      lt_q <= 25'h0;
      qt_q <= 2'h0;
      ok_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == 10'h000) lk_q <= reg_wdata_i[23:0];
      if (reg_wr_i && reg_addr_i == 10'h004) ct_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 10'h008) lt_q <= reg_wdata_i[24:0];
      if (reg_wr_i && reg_addr_i == 10'h008) ok_q <= 1'b1;
      qt_q <= reg_wr_i ? 2'h0 : qt_q + {1'b0, qt_q != 2'h3};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_link_readback: assert property (
    ok_q && reg_rd_i && reg_addr_i == 10'h000 |=>
    reg_rdata_o == {8'h00, $past(lk_q)}) else $error("link readback");
  a_status_pins: assert property (
    reg_rd_i && reg_addr_i == 10'h00c |=>
    reg_rdata_o[15:8] == $past(aux_output_pin_i, 2))
    else $error("pin status");
  a_drive_enable: assert property (
    reg_wr_i && reg_addr_i == 10'h004 |-> ##2
    aux_output_pin_oe_o == $past(reg_wdata_i[31:24], 2))
    else $error("drive enable");
  a_raw_source: assert property (
    st && !ct_q[19] |->
    aux_output_pin_o[3] == $past(raw_substrate_clock_i))
    else $error("raw source");
  a_probe_view: assert property (
    st && lt_q[24] && !ct_q[16] |->
    aux_output_pin_o[0] == $past(internal_clock_i)) else $error("probe");
  a_held_on: assert property (
    st && lk_q[2:0] == 3'h7 && ct_q[16] && !lt_q[0] |->
    aux_output_pin_o[0]) else $error("held on");
  a_start_level: assert property (
    st && lk_q[2:0] == 3'h0 && ct_q[16] && !lt_q[0] |->
    aux_output_pin_o[0] == ct_q[8]) else $error("start level");
  a_pair_table: assert property (
    st && lk_q[5:0] == 6'h0 && ct_q[16] && lt_q[0] |->
    aux_output_pin_o[0] == lt_q[ct_q[9:8] + 8]) else $error("pair table");
endmodule

bind fsao_top fsao_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .raw_substrate_clock_i(raw_substrate_clock_i),
  .internal_clock_i(internal_clock_i),
  .aux_output_pin_i(aux_output_pin_i),
  .aux_output_pin_o(aux_output_pin_o),
  .aux_output_pin_oe_o(aux_output_pin_oe_o));

// *** dv/fsao_partner.sv ***
`timescale 1ns/1ps
module fsao_partner (
  // Block side
  input  wire [7:0] pin_i,
  input  wire [7:0] pin_oe_i,
  // Outside drive
  input  wire [7:0] ext_i,
  output wire [7:0] level_o
);
  // Outside circuitry drives only the pins the block releases
  assign level_o = (pin_oe_i & pin_i) | (~pin_oe_i & ext_i);
endmodule

// *** dv/fsao_top_bench.sv ***
`timescale 1ns/1ps
module fsao_top_bench;
  reg         clk_i, rst_i, wr_s, rd_s, pa, fs;
  reg  [9:0]  addr;
  reg  [31:0] wd, v, d;
  reg  [12:0] ln, px, pf;
  reg  [7:0]  alt, ext, r;
  reg  [3:0]  t;
  wire [31:0] rdata;
  wire [7:0]  pin_o, oe, lvl;
  integer     n_mismatch, samples_checked, i;
  fsao_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .field_sync_i(fs), .pixel_tick_i(1'b1), .line_i(ln), .pixel_i(px),
    .mode_field_i(pf), .prim_field_i(pf), .prim_active_i(pa),
    .sec_field_i(pf), .sec_active_i(pa),
    .raw_substrate_clock_i(alt[3]), .vert_clock_21_i(alt[4]),
    .vert_clock_22_i(alt[5]), .vert_clock_23_i(alt[6]),
    .vert_clock_24_i(alt[7]), .internal_clock_i(alt[0]),
    .optical_black_clamp_i(alt[1]), .delayed_sample_clock_i(alt[2]),
    .aux_output_pin_i(lvl), .aux_output_pin_o(pin_o),
    .aux_output_pin_oe_o(oe));
  fsao_partner i_far (.pin_i(pin_o), .pin_oe_i(oe), .ext_i(ext),
    .level_o(lvl));
  always #12.5 clk_i = ~clk_i;
  task wr(input [9:0] a, input [31:0] x);
    begin
      @(posedge clk_i);
      addr <= a;
      wd <= x;
      wr_s <= 1'b1;
      @(posedge clk_i);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [9:0] a, output [31:0] x);
    begin
      @(posedge clk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_i);
      rd_s <= 1'b0;
      #1 x = rdata;
    end
  endtask
  task settle;
    begin
      repeat (5) @(posedge clk_i);
      #1;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task sweep(input [12:0] f, input a);
    integer k;
    begin
      pf <= f;
      pa <= a;
      ln <= 13'd5;
      for (k = 0; k < 12; k = k + 1) begin
        @(posedge clk_i);
        px <= k[12:0];
      end
      settle;
    end
  endtask
  function [7:0] pair(input [3:0] tb, input [7:0] s, input [7:0] rt);
    integer p;
    begin
      for (p = 0; p < 8; p = p + 1)
        pair[p] = rt[p] ? tb[{s[p | 1], s[p & 6]}] : s[p];
    end
  endfunction
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Normal run is well under a thousand cycles
  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    {clk_i, wr_s, rd_s, pa, fs, addr, wd, ln, px, pf, alt, ext} = 0;
    rst_i = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    v = $urandom(32'he1d3);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(10'h004, d);
    chk("ctrl reset", 32'h00ff0000, d);
    chk("oe reset", 32'h0, {24'h0, oe});
    for (i = 0; i < 8; i = i + 1) begin
      v = $urandom;
      ext <= v[31:24];
      wr(10'h000, v);
      wr(10'h008, v);
      wr(10'h3f0, v);
      rd(10'h000, d);
      chk("links", {8'h0, v[23:0]}, d);
      rd(10'h008, d);
      chk("lut cfg", {7'h0, v[24:0]}, d);
      rd(10'h3f0, d);
      chk("unmapped", 32'h0, d);
      rd(10'h00c, d);
      chk("pin in", {24'h0, v[31:24]}, {24'h0, d[15:8]});
    end
    wr(10'h004, 32'hffff0000);
    wr(10'h008, 32'h0);
    wr(10'h000, 32'hffffff);
    settle;
    chk("held on", 32'hff, {24'h0, pin_o});
    rd(10'h00c, d);
    chk("status", 32'hffff, {16'h0, d[15:0]});
    wr(10'h000, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      v = $urandom;
      t = 16'he876 >> (4 * i);
      r = i[0] ? 8'haa : 8'h55;
      wr(10'h004, {16'hffff, v[7:0], 8'h0});
      wr(10'h008, {8'h0, t, t, t, t, r});
      settle;
      chk("pair", {24'h0, pair(t, v[7:0], r)}, {24'h0, pin_o});
    end
    for (i = 0; i < 4; i = i + 1) begin
      alt <= 8'($urandom);
      wr(10'h008, {7'h0, i[0], 24'h0});
      wr(10'h004, 32'hff000000);
      settle;
      chk("alt", {24'h0, alt[7:3], alt[2:0] & {3{i[0]}}}, {24'h0, pin_o});
    end
    wr(10'h004, 32'hffff0000);
    wr(10'h008, 32'h0);
    wr(10'h100, {6'h0, 13'd7, 13'd5});
    wr(10'h104, {1'b1, 18'h0, 13'd1});
    wr(10'h120, {6'h0, 13'd7, 13'd5});
    wr(10'h124, {1'b1, 18'h0, 13'd2});
    wr(10'h000, 32'h2d);
    for (i = 0; i < 4; i = i + 1) begin
      sweep(i == 2 ? 13'd2 : 13'd1, i != 1);
      chk("sched", {31'h0, i != 3}, {30'h0, pin_o[1:0]});
    end
    // One-shot: armed fire acts in the next field only
    wr(10'h000, 32'h1);
    wr(10'h004, 32'hffff0001);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk_i);
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
      sweep(13'd0, 1'b0);
      chk("one shot", 32'h1, {30'h0, pin_o[1:0]});
    end
    wr(10'h000, 32'h0);
    settle;
    // Mode counter runs always; secondary follows its own active input
    for (i = 0; i < 2; i = i + 1) begin
      wr(10'h000, i[0] ? 32'h6 : 32'h4);
      sweep(13'd1, 1'b1);
      chk("link cnt", {31'h0, i == 0}, {30'h0, pin_o[1:0]});
    end
    summarize;
  end
endmodule
